//--- hdl/embc_ctrl.sv
// External memory bus controller: configuration, wait states, write
// styles, pin ownership and pull-up enables for a multiplexed bus.
// Assumes straps are stable from reset and a CPU table unit that
// holds one request until done.
`timescale 1ns/100ps
module embc_ctrl #(
  parameter logic [20:0] ONCHIP_SIZE = embc_pkg::ONCHIP_BYTES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Nonvolatile configuration straps
  input wire embc_pkg::embc_cfg_t cfg_straps,
  // Table unit request and answer
  input wire logic req_valid,
  input wire embc_pkg::embc_req_t req,
  output logic rsp_done,
  output logic rsp_err,
  output logic [7:0] rsp_data,
  // Multiplexed address/data lines
  input wire logic [15:0] ad_i,
  output logic [15:0] ad_o,
  output logic [15:0] ad_oe,
  // Top address lines
  output logic [3:0] top_addr_o,
  output logic [3:0] top_addr_oe,
  // Control lines and their ownership
  output embc_pkg::embc_ctl_t ctl_o,
  output logic ctl_own,
  // Weak pull-up enables per port
  output logic pu_low,
  output logic pu_high,
  output logic pu_ctl
);

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} embc_state_t;

  // Lines in use for a given mode
  function automatic logic [4:0] addr_lines(input logic [1:0] mode);
    case (mode)
      embc_pkg::MODE_A20: addr_lines = 5'h14;
      embc_pkg::MODE_A16: addr_lines = 5'h10;
      embc_pkg::MODE_A12: addr_lines = 5'h0C;
      default: addr_lines = 5'h00;
    endcase
  endfunction

  // Wait cycles for a code and strap
  function automatic logic [1:0] wait_of(input logic en,
                                         input logic [1:0] code);
    wait_of = en ? embc_pkg::WAIT_MAX - code : 2'h0;
  endfunction

  // Straps, caught once after reset release
  embc_pkg::embc_cfg_t cfg_q;
  logic cfg_ok_q;
  // Software registers
  logic [7:0] memctl_q;
  logic [7:0] pullup_q;
  // Sequencer and captured request
  embc_state_t state_q, state_d;
  embc_pkg::embc_req_t req_q;
  logic [1:0] cnt_q, cnt_d;
  logic [7:0] hold_q;
  // Pin synchroniser stages and filtered value
  logic [15:0] ad_s1_q, ad_s2_q, ad_s3_q, ad_f_q;
  // Agreed pin value, one net per bit from the filter loop
  wire logic [15:0] ad_f_d;
  // Pin registers
  logic [15:0] ad_o_q, ad_o_d, ad_oe_q, ad_oe_d;
  logic [3:0] top_o_q, top_o_d, top_oe_q, top_oe_d;
  embc_pkg::embc_ctl_t ctl_q, ctl_d;
  logic own_q, own_d;
  // Answer registers
  logic done_q, err_q;
  logic [7:0] rdata_q, rsp_q;
  // Helper length counter for checks
  logic [2:0] plen_q;

  // Decoded configuration
  wire logic bus_on = cfg_q.mode != embc_pkg::MODE_ONCHIP;
  wire logic bus_dis = memctl_q[embc_pkg::BIT_BUS_DIS];
  wire logic [1:0] wait_code = memctl_q[embc_pkg::BIT_WAIT_HI:
                                        embc_pkg::BIT_WAIT_LO];
  wire logic [1:0] wm = memctl_q[embc_pkg::BIT_WM_HI:embc_pkg::BIT_WM_LO];
  wire logic [1:0] delay = wait_of(cfg_q.wait_en, wait_code);
  wire logic [4:0] nlines = addr_lines(cfg_q.mode);
  wire logic word_wr = wm[1];
  wire logic a20 = cfg_q.mode == embc_pkg::MODE_A20;
  // Register decode
  wire logic hit_ctl = reg_addr == embc_pkg::OFS_MEM_CTRL;
  wire logic hit_pu = reg_addr == embc_pkg::OFS_PULLUP;
  wire logic hit_st = reg_addr == embc_pkg::OFS_STATUS;
  wire logic [7:0] status = {3'h0, state_q != ST_IDLE, cfg_q.wait_en,
                             cfg_q.shift, cfg_q.data16, bus_on};
  wire logic [7:0] rd_mux = hit_ctl ? memctl_q :
                            hit_pu ? pullup_q :
                            hit_st ? status : 8'h00;

  // Address shift; default passes the program address untouched
  // Address phase is set up while idle, before the capture lands
  wire embc_pkg::embc_req_t cur = (state_q == ST_IDLE) ? req : req_q;
  wire logic [20:0] eff = cfg_q.shift ? cur.addr - ONCHIP_SIZE
                                      : cur.addr;
  wire logic lsb = eff[0];
  // Word address on 16-bit data, byte address on 8-bit
  wire logic [19:0] baddr = cfg_q.data16 ? eff[20:1] : eff[19:0];
  // Byte-address line only in 20-bit, with 8-bit data or byte select
  wire logic ba_use = a20 && (!cfg_q.data16 ||
                              wm == embc_pkg::WM_BYTE_SEL);
  // Data phase classes
  wire logic wr16 = req_q.write && cfg_q.data16;
  wire logic even_word = wr16 && word_wr && !lsb;
  wire logic [15:0] wdata = !cfg_q.data16 ? {baddr[15:8], req_q.data} :
                            (word_wr ? {req_q.data, hold_q}
                                     : {req_q.data, req_q.data});
  // Lines that carry data in the data phase
  wire logic [15:0] mux_mask = cfg_q.data16 ? 16'hFFFF : 16'h00FF;
  // Lines inside the address width; 12-bit keeps only the low twelve
  wire logic [15:0] width_mask = (nlines < 5'h10) ? 16'h0FFF
                                                  : 16'hFFFF;

  // Sequencer next state and wait count
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        // Accept only once straps are known and bus exists
        if (req_valid && cfg_ok_q && bus_on) begin
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // Waits extend the data phase after its own cycle
        state_d = ST_DATA;
        cnt_d = delay;
      end
      ST_DATA: begin
        if (cnt_q == 2'h0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  wire logic active_d = state_d != ST_IDLE;
  wire logic data_d = state_d == ST_DATA;

  // Pin values for the coming cycle
  always_comb begin
    ad_o_d = 16'h0000;
    ad_oe_d = 16'h0000;
    top_o_d = 4'h0;
    top_oe_d = 4'h0;
    ctl_d = embc_pkg::CTL_IDLE;
    // Ownership ends with the access when bus disable is set
    own_d = bus_on && (!bus_dis || active_d);
    if (active_d) begin
      ctl_d.ce_n = 1'b0;
      ctl_d.ba0 = ba_use & lsb;
      top_o_d = baddr[19:16];
      // Lines above the width stay with the port
      top_oe_d = a20 ? 4'hF : 4'h0;
      if (!data_d) begin
        ctl_d.ale = 1'b1;
        ad_o_d = baddr[15:0];
        ad_oe_d = 16'hFFFF;
      end else if (!req_q.write) begin
        // Read: float multiplexed lines, keep address-only ones
        ctl_d.oe_n = 1'b0;
        ctl_d.ub_n = !cfg_q.data16;
        ctl_d.lb_n = !cfg_q.data16;
        ad_o_d = baddr[15:0];
        ad_oe_d = ~mux_mask;
      end else if (!cfg_q.data16) begin
        // Narrow write on the low byte
        ctl_d.wrl_n = 1'b0;
        ad_o_d = wdata;
        ad_oe_d = 16'hFFFF;
      end else if (even_word) begin
        // Even word half only loads the holding latch
        ad_oe_d = 16'h0000;
      end else begin
        ad_o_d = wdata;
        ad_oe_d = 16'hFFFF;
        ctl_d.wrh_n = 1'b0;
        if (word_wr) begin
          ctl_d.ub_n = 1'b0;
          ctl_d.lb_n = 1'b0;
        end else if (wm == embc_pkg::WM_BYTE_SEL) begin
          ctl_d.ub_n = !lsb;
          ctl_d.lb_n = lsb;
        end else begin
          ctl_d.wrh_n = !lsb;
          ctl_d.wrl_n = lsb;
        end
      end
      // 12-bit width leaves upper lines to I/O, data or not
      ad_oe_d = ad_oe_d & width_mask;
    end
  end

  // Each pin passes three flops; a change counts when two agree
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_filt
      assign ad_f_d[gi] = (ad_s2_q[gi] == ad_s3_q[gi]) ? ad_s3_q[gi]
                                                       : ad_f_q[gi];
    end
  endgenerate

  // Strap capture after reset release; never written again
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= '0;
      cfg_ok_q <= 1'b0;
    end else if (!cfg_ok_q) begin
      cfg_q <= cfg_straps;
      cfg_ok_q <= 1'b1;
    end
  end

  // Software registers; control locked in on-chip mode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      memctl_q <= embc_pkg::RST_MEM_CTRL;
      pullup_q <= embc_pkg::RST_PULLUP;
    end else begin
      if (reg_wr && hit_ctl && bus_on && cfg_ok_q) begin
        memctl_q <= reg_wdata & embc_pkg::MASK_MEM_CTRL;
      end
      if (reg_wr && hit_pu) begin
        pullup_q <= reg_wdata;
      end
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Sequencer, request capture and holding latch
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      req_q <= '0;
      hold_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == ST_IDLE && state_d == ST_ADDR) begin
        req_q <= req;
      end
      if (state_q == ST_ADDR && even_word) begin
        hold_q <= req_q.data;
      end
    end
  end

  // Answer: done pulse, error for requests with no bus
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      rsp_q <= 8'h00;
    end else begin
      done_q <= (state_q == ST_DATA && state_d == ST_IDLE) ||
                (req_valid && cfg_ok_q && !bus_on && !done_q);
      err_q <= req_valid && cfg_ok_q && !bus_on && !done_q;
      if (state_q == ST_DATA && state_d == ST_IDLE && !req_q.write) begin
        // Agreed value saves a cycle; needs the full three waits
        rsp_q <= (cfg_q.data16 && lsb) ? ad_f_d[15:8] : ad_f_d[7:0];
      end
    end
  end

  // Pin synchroniser and pin registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ad_s1_q <= 16'h0000;
      ad_s2_q <= 16'h0000;
      ad_s3_q <= 16'h0000;
      ad_f_q <= 16'h0000;
      ad_o_q <= 16'h0000;
      ad_oe_q <= 16'h0000;
      top_o_q <= 4'h0;
      top_oe_q <= 4'h0;
      ctl_q <= embc_pkg::CTL_IDLE;
      own_q <= 1'b0;
    end else begin
      ad_s1_q <= ad_i;
      ad_s2_q <= ad_s1_q;
      ad_s3_q <= ad_s2_q;
      ad_f_q <= ad_f_d;
      ad_o_q <= ad_o_d;
      ad_oe_q <= ad_oe_d;
      top_o_q <= top_o_d;
      top_oe_q <= top_oe_d;
      ctl_q <= ctl_d;
      own_q <= own_d;
    end
  end

  // Data phase length, for checks only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      plen_q <= 3'h0;
    end else begin
      plen_q <= (state_q == ST_DATA) ? plen_q + 3'h1 : 3'h0;
    end
  end

  // Outputs straight from flops; top lines have no pull-up
  assign reg_rdata = rdata_q;
  assign rsp_done = done_q;
  assign rsp_err = err_q;
  assign rsp_data = rsp_q;
  assign ad_o = ad_o_q;
  assign ad_oe = ad_oe_q;
  assign top_addr_o = top_o_q;
  assign top_addr_oe = top_oe_q;
  assign ctl_o = ctl_q;
  assign ctl_own = own_q;
  assign pu_low = pullup_q[embc_pkg::BIT_PU_LOW];
  assign pu_high = pullup_q[embc_pkg::BIT_PU_HIGH];
  assign pu_ctl = pullup_q[embc_pkg::BIT_PU_CTL];

  // Data phase lasts one cycle plus the decoded wait
  a_wait_length: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_DATA && state_d == ST_IDLE) |->
      plen_q == {1'b0, wait_of(cfg_q.wait_en, wait_code)})
    else $error("data phase length differs from wait code");

  // No strap, no waits
  a_no_wait: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (!cfg_q.wait_en && state_q == ST_ADDR) |=> ##1 state_q == ST_IDLE)
    else $error("wait inserted while waits disabled");

  // Even word half strobes nothing and floats the multiplexed lines
  a_word_even: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_DATA && even_word) |->
      (ctl_o.wrh_n && ctl_o.wrl_n && ad_oe == 16'h0000))
    else $error("even word write strobed or drove bus");

  // Odd word half writes new byte high and held byte low
  a_word_odd: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_DATA && wr16 && word_wr && lsb) |->
      (!ctl_o.wrh_n && ad_o == {req_q.data, hold_q}))
    else $error("word write output wrong");

  // Byte select: copies and one enable
  a_byte_sel: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_DATA && wr16 && wm == embc_pkg::WM_BYTE_SEL) |->
      (ad_o[15:8] == ad_o[7:0] && !ctl_o.wrh_n &&
       ctl_o.ub_n == !lsb && ctl_o.lb_n == lsb))
    else $error("byte select write wrong");

  // Byte write: exactly one strobe by the LSB
  a_byte_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_DATA && wr16 && wm == embc_pkg::WM_BYTE_WRITE) |->
      (ctl_o.wrh_n == !lsb && ctl_o.wrl_n == lsb))
    else $error("byte write strobe wrong");

  // Idle bus shows inactive controls, floats data
  a_idle_ctl: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_IDLE) |->
      (ctl_o == embc_pkg::CTL_IDLE && ad_oe == 16'h0000))
    else $error("idle bus not parked");

  // Top lines free outside 20-bit mode
  a_top_free: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (cfg_q.mode != embc_pkg::MODE_A20) |-> top_addr_oe == 4'h0)
    else $error("top address lines driven");

  // Straps never change once caught
  a_cfg_fixed: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    cfg_ok_q |=> $stable(cfg_q))
    else $error("configuration changed at run time");

  // Pull-up enables follow the port write
  a_pullup_wr: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_wr && hit_pu) |=>
      {pu_low, pu_high, pu_ctl} == $past(reg_wdata[7:5]))
    else $error("pull-up enables not updated");

endmodule

//--- hdl/embc_pkg.sv
// Package for the external memory bus controller: register map,
// field positions, configuration encodings and the carrier structs.
// Assumes one 100 MHz clock; one clock stands for one bus cycle.
package embc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] OFS_MEM_CTRL = 4'h0;
  localparam logic [3:0] OFS_PULLUP = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  // Bus control register fields
  localparam int BIT_BUS_DIS = 7;
  localparam int BIT_WAIT_HI = 5;
  localparam int BIT_WAIT_LO = 4;
  localparam int BIT_WM_HI = 1;
  localparam int BIT_WM_LO = 0;
  // Pull-up enables in the port data register
  localparam int BIT_PU_LOW = 7;
  localparam int BIT_PU_HIGH = 6;
  localparam int BIT_PU_CTL = 5;
  // Reset values
  localparam logic [7:0] RST_MEM_CTRL = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  // Implemented bits of the bus control register
  localparam logic [7:0] MASK_MEM_CTRL = 8'hB3;
  // Memory mode / address width encodings
  localparam logic [1:0] MODE_A20 = 2'h0;
  localparam logic [1:0] MODE_A16 = 2'h1;
  localparam logic [1:0] MODE_A12 = 2'h2;
  localparam logic [1:0] MODE_ONCHIP = 2'h3;
  // Wide write styles
  localparam logic [1:0] WM_BYTE_WRITE = 2'h0;
  localparam logic [1:0] WM_BYTE_SEL = 2'h1;
  // Wait codes: most delay at code zero
  localparam logic [1:0] WAIT_MAX = 2'h3;
  // One instruction cycle per clock
  localparam int TCY_NS = 10;
  localparam int CLK_NS = 10;
  localparam int TCY_CLKS = TCY_NS / CLK_NS;
  // Default on-chip program memory size in bytes
  localparam logic [20:0] ONCHIP_BYTES = 21'h020000;
  // Table operation request from the CPU side
  typedef struct packed {
    logic write;
    logic [20:0] addr;
    logic [7:0] data;
  } embc_req_t;
  // Bus control pins, active-low ones named so
  typedef struct packed {
    logic ale;
    logic oe_n;
    logic wrl_n;
    logic wrh_n;
    logic ba0;
    logic ce_n;
    logic lb_n;
    logic ub_n;
  } embc_ctl_t;
  localparam embc_ctl_t CTL_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
                                     1'b1, 1'b1};
  // Nonvolatile configuration straps
  typedef struct packed {
    logic wait_en;
    logic shift;
    logic data16;
    logic [1:0] mode;
  } embc_cfg_t;
endpackage

//--- test/embc_mem_model.sv
// Byte memory standing on the far side of the multiplexed lines.
// Assumes control pins arrive as the package struct, one clock.
`timescale 1ns/100ps
module embc_mem_model (
  // Clock
  input wire logic clk_sys,
  // Pins from the controller
  input wire logic [15:0] ad_o,
  input wire logic [15:0] ad_oe,
  input wire embc_pkg::embc_ctl_t ctl_o,
  // Weak pull-up enables of the two line ports
  input wire logic pu_low,
  input wire logic pu_high,
  // Resolved line levels
  output logic [15:0] ad_i
);
  logic [3:0] addr_q = 4'h0; // Latched low address
  logic [7:0] mem_q [16] = '{default: 8'h00}; // Small byte store
  logic [15:0] last_q = 16'h0000; // Previous line levels
  wire wr_now = !ctl_o.wrl_n || !ctl_o.wrh_n; // Either strobe low
  wire rd_now = !ctl_o.oe_n && !ctl_o.ce_n; // Memory drives lines
  // Released lines carry memory data on a read, else toggle unless pulled up, so a stale value never looks valid
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (ad_oe[i])
        ad_i[i] = ad_o[i];
      else if (rd_now)
        ad_i[i] = mem_q[addr_q][i % 8];
      else if (i < 8 ? pu_low : pu_high)
        ad_i[i] = 1'b1;
      else
        ad_i[i] = ~last_q[i];
    end
  end
  // Address latch and byte capture while a strobe is low
  always @(posedge clk_sys) begin
    last_q <= ad_i;
    if (ctl_o.ale)
      addr_q <= ad_o[3:0];
    if (wr_now)
      mem_q[addr_q] <= ad_i[7:0];
  end
endmodule

//--- test/embc_ctrl_bench.sv
// Bench for the bus controller: register port, strap sets, wait
// counts, write styles, address forms and pin ownership.
// Assumes the byte memory model on the far side of the lines.
`timescale 1ns/100ps
module embc_ctrl_bench;
  localparam logic [20:0] SHIFT_SZ = 21'h001000; // Small on-chip size
  logic clk_sys = 1'b0; // 100 MHz clock
  logic nrst = 1'b0; // Reset, active low
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rsp_data, rd;
  embc_pkg::embc_cfg_t cfg_straps = '0; // Straps per test
  logic req_valid = 1'b0;
  embc_pkg::embc_req_t req = '0;
  logic rsp_done, rsp_err, ctl_own, pu_low, pu_high, pu_ctl;
  logic [15:0] ad_i, ad_o, ad_oe;
  logic [3:0] top_addr_o, top_addr_oe;
  embc_pkg::embc_ctl_t ctl_o;
  int num_errors = 0;
  int samples_checked = 0;
  // Observations of the last table operation
  int n_cyc;
  logic [15:0] ale_ad, st_ad, oe_any;
  logic [3:0] ale_top, top_any;
  logic [4:0] strb; // {wrh, wrl, ub, lb, ba0} seen active
  logic own_any, err_seen;
  // Write style cases: even then odd address per style code
  logic [7:0] st_d [8] = '{8'hA5, 8'hA5, 8'hC3, 8'hC3,
                           8'h11, 8'h22, 8'h33, 8'h44};
  logic [4:0] st_ex [8] = '{5'h08, 5'h10, 5'h12, 5'h15,
                            5'h00, 5'h16, 5'h00, 5'h16};
  logic [4:0] st_mk [8] = '{5'h19, 5'h19, 5'h1F, 5'h1F,
                            5'h18, 5'h1E, 5'h18, 5'h1E};
  logic [7:0] pu_vals [5] = '{8'h1F, 8'h20, 8'h40, 8'h80, 8'hE0};

  always #5 clk_sys = ~clk_sys;

  embc_ctrl #(.ONCHIP_SIZE(SHIFT_SZ)) embc_ctrl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_straps(cfg_straps),
    .req_valid(req_valid), .req(req), .rsp_done(rsp_done),
    .rsp_err(rsp_err), .rsp_data(rsp_data), .ad_i(ad_i), .ad_o(ad_o),
    .ad_oe(ad_oe), .top_addr_o(top_addr_o), .top_addr_oe(top_addr_oe),
    .ctl_o(ctl_o), .ctl_own(ctl_own), .pu_low(pu_low),
    .pu_high(pu_high), .pu_ctl(pu_ctl));
  embc_mem_model embc_mem_model_inst (.clk_sys(clk_sys), .ad_o(ad_o),
    .ad_oe(ad_oe), .ctl_o(ctl_o), .pu_low(pu_low), .pu_high(pu_high),
    .ad_i(ad_i));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Straps change only under reset, as real fuses would
  task automatic do_reset(input embc_pkg::embc_cfg_t c);
    nrst <= 1'b0;
    cfg_straps <= c;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // One table operation, watching the pins each cycle
  task automatic tbl_op(input logic w, input logic [20:0] a,
                        input logic [7:0] d);
    n_cyc = 0;
    strb = '0;
    oe_any = '0;
    top_any = '0;
    own_any = 1'b0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{w, a, d};
    for (int n = 1; n <= 20 && n_cyc == 0; n++) begin
      @(posedge clk_sys);
      #1;
      if (ctl_o.ale) begin
        ale_ad = ad_o;
        ale_top = top_addr_o;
        strb[0] = ctl_o.ba0;
      end
      if (!ctl_o.wrh_n || !ctl_o.wrl_n)
        st_ad = ad_o;
      strb[4:1] = strb[4:1] |
                  ~{ctl_o.wrh_n, ctl_o.wrl_n, ctl_o.ub_n, ctl_o.lb_n};
      oe_any = oe_any | ad_oe;
      top_any = top_any | top_addr_oe;
      own_any = own_any | ctl_own;
      // Request must be gone before the next edge
      if (rsp_done === 1'b1) begin
        n_cyc = n;
        err_seen = rsp_err;
        req_valid <= 1'b0;
      end
    end
    if (n_cyc == 0) begin
      num_errors++;
      final_report();
    end
  endtask

  initial begin
    // Waits on, 20-bit address, 16-bit data
    do_reset('{1'b1, 1'b0, 1'b1, embc_pkg::MODE_A20});
    check({pu_low, pu_high, pu_ctl}, 3'b000);
    reg_read(embc_pkg::OFS_PULLUP, rd);
    check(rd, embc_pkg::RST_PULLUP);
    reg_read(embc_pkg::OFS_MEM_CTRL, rd);
    check(rd, embc_pkg::RST_MEM_CTRL);
    reg_read(4'hF, rd);
    check(rd, 8'h00);
    reg_write(embc_pkg::OFS_STATUS, 8'h00);
    reg_read(embc_pkg::OFS_STATUS, rd);
    check(rd, 8'h0B);
    foreach (pu_vals[i]) begin
      reg_write(embc_pkg::OFS_PULLUP, pu_vals[i]);
      reg_read(embc_pkg::OFS_PULLUP, rd);
      check(rd, pu_vals[i]);
      check({pu_low, pu_high, pu_ctl}, pu_vals[i][7:5]);
    end
    reg_write(embc_pkg::OFS_MEM_CTRL, 8'hFF);
    reg_read(embc_pkg::OFS_MEM_CTRL, rd);
    check(rd, embc_pkg::MASK_MEM_CTRL);
    check(ctl_own, 1'b0);
    $display("test registers done");
    // Every wait code, bus enabled
    for (int c = 0; c < 4; c++) begin
      reg_write(embc_pkg::OFS_MEM_CTRL, {2'b00, c[1:0], 4'h0});
      tbl_op(1'b1, 21'h000101, 8'h5A);
      check(n_cyc, 6 - c);
      check(ctl_o, embc_pkg::CTL_IDLE);
      check(ad_oe, 16'h0000);
      check(ctl_own, 1'b1);
    end
    $display("test waits done");
    // Every write style, even and odd address, no waits
    foreach (st_d[i]) begin
      reg_write(embc_pkg::OFS_MEM_CTRL, {6'h0C, i[2:1]});
      tbl_op(1'b1, 21'h1F2468 | i[0], st_d[i]);
      check(strb & st_mk[i], st_ex[i]);
      check({ale_top, ale_ad}, 20'hF9234);
      if (i < 4)
        check(st_ad, {st_d[i], st_d[i]});
      else if (i[0])
        check(st_ad, {st_d[i], st_d[i - 1]});
    end
    $display("test write styles done");
    // Waits off, shifted address, 16-bit address
    do_reset('{1'b0, 1'b1, 1'b1, embc_pkg::MODE_A16});
    check({pu_low, pu_high, pu_ctl}, 3'b000);
    reg_read(embc_pkg::OFS_STATUS, rd);
    check(rd, 8'h07);
    tbl_op(1'b1, SHIFT_SZ + 21'h000246, 8'h77);
    check(n_cyc, 3);
    check(ale_ad, 16'h0123);
    check(top_any, 4'h0);
    reg_write(embc_pkg::OFS_MEM_CTRL, 8'h80);
    reg_read(embc_pkg::OFS_MEM_CTRL, rd);
    check({rd, ctl_own}, 9'h100);
    tbl_op(1'b0, SHIFT_SZ, 8'h00);
    check(own_any, 1'b1);
    check(top_any, 4'h0);
    $display("test shift and disable done");
    // 12-bit address with 16-bit data
    do_reset('{1'b1, 1'b0, 1'b1, embc_pkg::MODE_A12});
    tbl_op(1'b1, 21'h000002, 8'h99);
    check(oe_any, 16'h0FFF);
    check(top_any, 4'h0);
    $display("test narrow address done");
    // 8-bit data: write then read back through the memory
    do_reset('{1'b1, 1'b0, 1'b0, embc_pkg::MODE_A16});
    reg_read(embc_pkg::OFS_STATUS, rd);
    check(rd, 8'h09);
    tbl_op(1'b1, 21'h000007, 8'h3C);
    check(n_cyc, 6);
    check(strb[4:3], 2'b01);
    check(st_ad[7:0], 8'h3C);
    check(ale_ad, 16'h0007);
    tbl_op(1'b0, 21'h000007, 8'h00);
    check(rsp_data, 8'h3C);
    $display("test byte bus done");
    // On-chip only: no bus, control register locked
    do_reset('{1'b1, 1'b0, 1'b1, embc_pkg::MODE_ONCHIP});
    reg_write(embc_pkg::OFS_MEM_CTRL, 8'h30);
    reg_read(embc_pkg::OFS_MEM_CTRL, rd);
    check(rd, 8'h00);
    tbl_op(1'b1, 21'h000010, 8'h01);
    check({err_seen, n_cyc[3:0]}, 5'h11);
    check({own_any, oe_any}, 17'h00000);
    $display("test on-chip done");
    final_report();
  end
endmodule
